// *** core/wds_pkg.sv ***
// constants for the watchdog and supply supervisor
package wds_pkg;
    // register indexes on the 4-bit address
    localparam logic [3:0] FLAGS_IDX = 4'h0;
    localparam logic [3:0] INTR_IDX = 4'h6;
    localparam logic [3:0] WDT_IDX = 4'h7;
    // field positions
    localparam int FLAG_BIT = 7;
    localparam int STEER_BIT = 7;
    localparam int MULT_LSB = 2;
    localparam int ALARM_EN_BIT = 7;
    localparam int ALARM_BKUP_BIT = 5;
    // reset values
    localparam logic [7:0] WDT_RST = 8'h00;
    localparam logic [7:0] INTR_RST = 8'h00;
    // resolution codes
    localparam logic [1:0] RES_16TH = 2'h0;
    localparam logic [1:0] RES_QTR = 2'h1;
    localparam logic [1:0] RES_ONE = 2'h2;
    localparam logic [1:0] RES_FOUR = 2'h3;
    // step lengths in sixteenth-second ticks
    localparam logic [6:0] STEP_16TH = 7'h01;
    localparam logic [6:0] STEP_QTR = 7'h04;
    localparam logic [6:0] STEP_ONE = 7'h10;
    localparam logic [6:0] STEP_FOUR = 7'h40;
    // timebase
    localparam int OSC_HZ = 32768;
    localparam int TICK_HZ = 16;
    localparam int TICK_DIV = OSC_HZ / TICK_HZ;
    // core clock and supply periods
    localparam int CLK_KHZ = 100000;
    localparam int REC_TIME_MS = 2;
    localparam int RPU_TIME_MS = 200;
    localparam int REC_CYC = REC_TIME_MS * CLK_KHZ;
    localparam int RPU_CYC = RPU_TIME_MS * CLK_KHZ;
    // pin sampler width
    localparam int PIN_W = 19;
    // supply states
    typedef enum logic [1:0] {
        PS_UP = 2'b00,
        PS_RUN = 2'b01,
        PS_FAIL = 2'b10
    } wds_pwr_t;
endpackage : wds_pkg

// *** core/wds_top.sv ***
// watchdog timer and supply supervisor behind an asynchronous register port
`timescale 1ns/1ps
`default_nettype none
module wds_top #(
    parameter int REC_CYCLES = wds_pkg::REC_CYC,
    parameter int RPU_CYCLES = wds_pkg::RPU_CYC
) (
    input wire logic core_clk, // 100 MHz core clock
    input wire logic rst_n, // power-on reset
    input wire logic osc_32k, // oscillator pin
    input wire logic supply_ok, // supply above trip
    input wire logic supply_above_batt, // supply above battery
    input wire logic clk_sel_n, // clock select
    input wire logic mem_sel_n, // memory select
    input wire logic wr_en_n, // write enable
    input wire logic out_en_n, // output enable
    input wire logic [3:0] addr, // register address
    input wire logic [7:0] dq_in, // data pins in
    output logic [7:0] dq_out, // data pins out
    output logic dq_oe, // data pins driven
    output logic interrupt_test_out_n, // open-drain level
    output logic interrupt_test_oe, // pull low
    output logic supply_reset_out_n, // open-drain level
    output logic supply_reset_oe // pull low
);
    import wds_pkg::*;

    // three-stage pin sampler with agree filter
    logic [PIN_W-1:0] pin_raw, s1, s2, s3, filt, next_filt;
    assign pin_raw = {osc_32k, supply_ok, supply_above_batt, clk_sel_n,
                      mem_sel_n, wr_en_n, out_en_n, addr, dq_in};
    always_comb begin
        next_filt = ((s2 ~^ s3) & s2) | ((s2 ^ s3) & filt);
    end
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            s1 <= '0;
            s2 <= '0;
            s3 <= '0;
            filt <= '0;
        end else begin
            s1 <= pin_raw;
            s2 <= s1;
            s3 <= s2;
            filt <= next_filt;
        end
    end

    logic osc_f, ok_f, above_f, cs_f, ce_f, we_f, oe_f;
    logic [3:0] addr_f;
    logic [7:0] din_f;
    assign {osc_f, ok_f, above_f, cs_f, ce_f, we_f, oe_f, addr_f,
            din_f} = filt;

    // supply state, hold counter, write protect
    wds_pwr_t pst, next_pst;
    logic [31:0] hold_cnt, next_hold_cnt;
    logic prot, next_prot, next_rst_drv, pwr_new;
    always_comb begin
        next_pst = pst;
        next_hold_cnt = hold_cnt;
        pwr_new = 1'b0;
        case (pst)
            PS_UP: begin
                if (!ok_f) begin
                    next_hold_cnt = '0;
                end else if (hold_cnt >= 32'(RPU_CYCLES)) begin
                    next_pst = PS_RUN;
                end else begin
                    next_hold_cnt = hold_cnt + 32'h1;
                end
            end
            PS_RUN: begin
                if (!ok_f) begin
                    next_pst = PS_FAIL;
                end
            end
            PS_FAIL: begin
                if (!above_f) begin
                    next_pst = PS_UP;
                    next_hold_cnt = '0;
                    pwr_new = 1'b1;
                end
            end
            default: begin
                next_pst = PS_UP;
                next_hold_cnt = '0;
            end
        endcase
        // protect at once on low supply, release after recovery
        next_prot = !ok_f || (pst == PS_FAIL) ||
            (pst == PS_UP && hold_cnt < 32'(REC_CYCLES));
        next_rst_drv = (next_pst != PS_RUN);
    end
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            pst <= PS_UP;
            hold_cnt <= '0;
            prot <= 1'b1;
        end else begin
            pst <= next_pst;
            hold_cnt <= next_hold_cnt;
            prot <= next_prot;
        end
    end

    // bus cycle decode, memory select must stay high
    logic acc, rd_act, wr_act, rd_q, wr_q, rd_start, wr_end;
    logic [3:0] wa_q;
    logic [7:0] wd_q;
    assign acc = !prot && ok_f && !cs_f && ce_f;
    assign rd_act = acc && we_f && !oe_f;
    assign wr_act = acc && !we_f;
    assign rd_start = rd_act && !rd_q;
    assign wr_end = wr_q && !wr_act && !prot && ok_f;
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            rd_q <= 1'b0;
            wr_q <= 1'b0;
            wa_q <= '0;
            wd_q <= '0;
        end else begin
            rd_q <= rd_act;
            wr_q <= wr_act;
            wa_q <= wr_act ? addr_f : wa_q;
            wd_q <= wr_act ? din_f : wd_q;
        end
    end

    logic wdt_acc, flag_rd;
    assign wdt_acc = (rd_start && addr_f == WDT_IDX) ||
                     (wr_end && wa_q == WDT_IDX);
    assign flag_rd = rd_start && addr_f == FLAGS_IDX;

    // control registers
    logic [7:0] wdt_ctrl, next_wdt_ctrl, intr_reg, next_intr_reg;
    always_comb begin
        next_wdt_ctrl = wdt_ctrl;
        next_intr_reg = intr_reg;
        if (pwr_new) begin
            next_wdt_ctrl = WDT_RST;
            next_intr_reg = INTR_RST;
        end else if (wr_end && wa_q == WDT_IDX) begin
            next_wdt_ctrl = wd_q;
        end else if (wr_end && wa_q == INTR_IDX) begin
            next_intr_reg = wd_q;
        end
    end

    logic steer;
    logic [4:0] mult;
    logic [1:0] res;
    assign steer = wdt_ctrl[STEER_BIT];
    assign mult = wdt_ctrl[MULT_LSB +: 5];
    assign res = wdt_ctrl[1:0];

    // sixteenth-second base tick from oscillator edges
    logic osc_q, tick;
    logic [10:0] div_cnt, next_div_cnt;
    always_comb begin
        tick = 1'b0;
        next_div_cnt = div_cnt;
        if (osc_f && !osc_q) begin
            if (div_cnt == 11'(TICK_DIV - 1)) begin
                next_div_cnt = '0;
                tick = 1'b1;
            end else begin
                next_div_cnt = div_cnt + 11'h1;
            end
        end
    end

    // step length per resolution code
    logic [6:0] step_len;
    always_comb begin
        case (res)
            RES_16TH: step_len = STEP_16TH;
            RES_QTR: step_len = STEP_QTR;
            RES_ONE: step_len = STEP_ONE;
            RES_FOUR: step_len = STEP_FOUR;
            default: step_len = STEP_16TH;
        endcase
    end

    // step and multiplier counters, timeout detect
    logic [6:0] step_cnt, next_step_cnt;
    logic [4:0] unit_cnt, next_unit_cnt;
    logic timeout;
    always_comb begin
        next_step_cnt = step_cnt;
        next_unit_cnt = unit_cnt;
        timeout = 1'b0;
        if (wdt_acc || pwr_new || mult == 5'h0) begin
            next_step_cnt = '0;
            next_unit_cnt = '0;
        end else if (tick) begin
            if (step_cnt == step_len - 7'h1) begin
                next_step_cnt = '0;
                if (unit_cnt == mult - 5'h1) begin
                    next_unit_cnt = '0;
                    timeout = 1'b1;
                end else begin
                    next_unit_cnt = unit_cnt + 5'h1;
                end
            end else begin
                next_step_cnt = step_cnt + 7'h1;
            end
        end
    end

    // timeout flag and interrupt, a new timeout beats a clear
    logic timeout_flag, next_timeout_flag, irq, next_irq;
    always_comb begin
        next_timeout_flag = timeout_flag;
        next_irq = irq;
        if (flag_rd || pwr_new) begin
            next_timeout_flag = 1'b0;
        end
        if (flag_rd || wdt_acc || pwr_new) begin
            next_irq = 1'b0;
        end
        if (timeout) begin
            next_timeout_flag = 1'b1;
            next_irq = !steer;
        end
    end

    // read data and pin drive
    logic [7:0] rd_val, next_dq_out;
    logic next_dq_oe;
    always_comb begin
        case (addr_f)
            FLAGS_IDX: rd_val = {timeout_flag, 7'h00};
            INTR_IDX: rd_val = intr_reg;
            WDT_IDX: rd_val = wdt_ctrl;
            default: rd_val = 8'h00;
        endcase
        next_dq_oe = rd_act;
        next_dq_out = rd_act ? rd_val : 8'h00;
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            wdt_ctrl <= WDT_RST;
            intr_reg <= INTR_RST;
            osc_q <= 1'b0;
            div_cnt <= '0;
            step_cnt <= '0;
            unit_cnt <= '0;
            timeout_flag <= 1'b0;
            irq <= 1'b0;
            dq_out <= 8'h00;
            dq_oe <= 1'b0;
        end else begin
            wdt_ctrl <= next_wdt_ctrl;
            intr_reg <= next_intr_reg;
            osc_q <= osc_f;
            div_cnt <= next_div_cnt;
            step_cnt <= next_step_cnt;
            unit_cnt <= next_unit_cnt;
            timeout_flag <= next_timeout_flag;
            irq <= next_irq;
            dq_out <= next_dq_out;
            dq_oe <= next_dq_oe;
        end
    end

    // open-drain outputs: level flops stay low, enables pull
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            interrupt_test_out_n <= 1'b0;
            interrupt_test_oe <= 1'b0;
            supply_reset_out_n <= 1'b0;
            supply_reset_oe <= 1'b1;
        end else begin
            interrupt_test_out_n <= 1'b0;
            interrupt_test_oe <= next_irq;
            supply_reset_out_n <= 1'b0;
            supply_reset_oe <= next_rst_drv;
        end
    end

    // checks
    sequence s_run_then_low;
        pst == PS_RUN && !ok_f;
    endsequence
    a_reset_on_fail: assert property (@(posedge core_clk)
        disable iff (!rst_n) s_run_then_low |=> supply_reset_oe [*2])
        else $error("reset output not driven on supply loss");
    a_fail_holds_reset: assert property (@(posedge core_clk)
        disable iff (!rst_n) pst == PS_FAIL && above_f |=> supply_reset_oe)
        else $error("reset released above battery level");
    a_prot_on_low: assert property (@(posedge core_clk)
        disable iff (!rst_n) !ok_f |=> prot && !dq_oe)
        else $error("bus not protected on low supply");
    a_up_no_access: assert property (@(posedge core_clk)
        disable iff (!rst_n) pst == PS_UP && hold_cnt < 32'(REC_CYCLES)
        |=> prot)
        else $error("access before recovery period");
    a_zero_no_flag: assert property (@(posedge core_clk)
        disable iff (!rst_n) mult == 5'h0 |=> !$rose(timeout_flag))
        else $error("timeout with watchdog disabled");
    a_expiry_irq: assert property (@(posedge core_clk)
        disable iff (!rst_n) timeout && !steer ##1 1'b1
        |-> timeout_flag && interrupt_test_oe)
        else $error("expiry did not raise flag and interrupt");
    a_irq_clear: assert property (@(posedge core_clk)
        disable iff (!rst_n) (flag_rd || wdt_acc) && !timeout
        |=> !interrupt_test_oe)
        else $error("interrupt not cleared by service");
    a_access_restart: assert property (@(posedge core_clk)
        disable iff (!rst_n) wdt_acc |=> step_cnt == 7'h0
        && unit_cnt == 5'h0)
        else $error("control access did not restart count");
    a_por_clear: assert property (@(posedge core_clk)
        !rst_n |=> wdt_ctrl == 8'h00 && intr_reg == 8'h00)
        else $error("control not cleared at power-up");
endmodule : wds_top
`default_nettype wire

// *** bench/wds_host.sv ***
// host processor model on the asynchronous register port
`timescale 1ns/1ps
`default_nettype none
module wds_host (
    input wire logic core_clk, // core clock
    input wire logic [7:0] dq_out, // read data
    input wire logic dq_oe, // data pins driven
    output logic clk_sel_n, // clock select
    output logic mem_sel_n, // memory select
    output logic wr_en_n, // write enable
    output logic out_en_n, // output enable
    output logic [3:0] addr, // register index
    output logic [7:0] dq_in // data pins
);
    logic drv = 1'b0;
    // idle bus, memory select never taken
    initial begin
        {clk_sel_n, mem_sel_n, wr_en_n, out_en_n} = 4'hF;
        addr = 4'h0;
        dq_in = 8'h00;
    end
    // released data pins toggle so stale values never pass
    always @(posedge core_clk) begin
        if (!drv) dq_in <= #1 ~dq_in;
    end
    // write: hold everything through the low phase
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        drv = 1'b1;
        @(posedge core_clk) #1;
        clk_sel_n = 1'b0;
        addr = a;
        dq_in = d;
        wr_en_n = 1'b0;
        repeat (5) @(posedge core_clk);
        #1 wr_en_n = 1'b1;
        repeat (5) @(posedge core_clk);
        #1 clk_sel_n = 1'b1;
        drv = 1'b0;
        repeat (5) @(posedge core_clk);
    endtask : wr
    // read: hold the request until data is driven, bounded
    task automatic rd(input logic [3:0] a, output logic [7:0] d,
                      output bit ok);
        int n = 0;
        ok = 1'b0;
        @(posedge core_clk) #1;
        clk_sel_n = 1'b0;
        addr = a;
        out_en_n = 1'b0;
        while (!ok && n < 12) begin
            @(posedge core_clk) #1;
            ok = (dq_oe === 1'b1);
            d = dq_out;
            n++;
        end
        {clk_sel_n, out_en_n} = 2'b11;
        repeat (5) @(posedge core_clk);
    endtask : rd
endmodule : wds_host
`default_nettype wire

// *** bench/watchdog_and_supply_supervisor_tb_top.sv ***
// self-checking bench for the watchdog and supply supervisor
`timescale 1ns/1ps
`default_nettype none
module watchdog_and_supply_supervisor_tb_top;
    import wds_pkg::*;
    localparam int REC = 20;
    localparam int RPU = 50;
    localparam int HALF = 2; // oscillator half period in core cycles
    logic core_clk = 1'b0;
    logic rst_n = 1'b0;
    logic osc_32k = 1'b0;
    logic supply_ok = 1'b0;
    logic supply_above_batt = 1'b1;
    logic clk_sel_n, mem_sel_n, wr_en_n, out_en_n;
    logic [3:0] addr;
    logic [7:0] dq_in, dq_out, rd_d;
    logic dq_oe, int_out_n, int_oe, rst_out_n, rst_oe, irq_pin_n, rst_pin_n;
    int miscompares = 0;
    int checks = 0;
    int seed = 93212;
    bit ok;
    // clocks; oscillator sped up to keep ticks short
    always #5 core_clk = ~core_clk;
    always begin
        repeat (HALF) @(posedge core_clk);
        #1 osc_32k = ~osc_32k;
    end
    // open-drain pins with pull-ups
    assign irq_pin_n = int_oe ? int_out_n : 1'b1;
    assign rst_pin_n = rst_oe ? rst_out_n : 1'b1;
    wds_top #(.REC_CYCLES(REC), .RPU_CYCLES(RPU)) u_dut (
        .core_clk(core_clk), .rst_n(rst_n), .osc_32k(osc_32k),
        .supply_ok(supply_ok), .supply_above_batt(supply_above_batt),
        .clk_sel_n(clk_sel_n), .mem_sel_n(mem_sel_n), .wr_en_n(wr_en_n),
        .out_en_n(out_en_n), .addr(addr), .dq_in(dq_in), .dq_out(dq_out),
        .dq_oe(dq_oe), .interrupt_test_out_n(int_out_n),
        .interrupt_test_oe(int_oe), .supply_reset_out_n(rst_out_n),
        .supply_reset_oe(rst_oe));
    wds_host u_host (
        .core_clk(core_clk), .dq_out(dq_out), .dq_oe(dq_oe),
        .clk_sel_n(clk_sel_n), .mem_sel_n(mem_sel_n), .wr_en_n(wr_en_n),
        .out_en_n(out_en_n), .addr(addr), .dq_in(dq_in));
    // cycles in n sixteenth-second ticks
    function automatic int tick_cyc(input int n);
        return n * TICK_DIV * 2 * HALF;
    endfunction : tick_cyc
    // control value, steering kept at zero
    function automatic logic [7:0] ctrl_of(input logic [4:0] m,
                                           input logic [1:0] r);
        return {1'b0, m, r};
    endfunction : ctrl_of
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checks++;
        if (got !== exp) begin
            miscompares++;
            $display("unexpected at %0t: got %h exp %h", $time, got, exp);
        end
    endtask : chk
    task automatic rdchk(input logic [3:0] a, input logic [7:0] m,
                         input logic [7:0] e);
        u_host.rd(a, rd_d, ok);
        chk({7'h00, ok}, 8'h01);
        chk(rd_d & m, e);
    endtask : rdchk
    // waits at most lim cycles for the interrupt or reset enable level
    task automatic wait_for(input bit use_irq, input logic v, input int lim,
                            output int n);
        n = 0;
        while ((use_irq ? int_oe : rst_oe) !== v && n < lim) begin
            @(posedge core_clk) #1;
            n++;
        end
    endtask : wait_for
    task automatic complete_run();
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : complete_run
    // watchdog against a hang
    initial begin
        #(100000 * 10);
        miscompares++;
        complete_run();
    end
    // main sequence
    initial begin
        int n;
        logic [7:0] v;
        repeat (4) @(posedge core_clk);
        #1 rst_n = 1'b1;
        chk({7'h00, rst_oe}, 8'h01);
        supply_ok = 1'b1;
        wait_for(1'b0, 1'b0, 200, n);
        chk({7'h00, n >= RPU && n <= RPU + 10}, 8'h01);
        rdchk(WDT_IDX, 8'hFF, WDT_RST);
        rdchk(INTR_IDX, 8'hA0, INTR_RST);
        rdchk(4'h3, 8'hFF, 8'h00);
        $display("test power-up done");
        // every resolution code with a random multiplier
        for (int i = 0; i < 4; i++) begin
            v = ctrl_of(5'($random(seed)), 2'(i));
            u_host.wr(WDT_IDX, v);
            rdchk(WDT_IDX, 8'hFF, v);
            v = 8'($random(seed));
            u_host.wr(INTR_IDX, v);
            rdchk(INTR_IDX, 8'hFF, v);
        end
        $display("test register access done");
        u_host.wr(WDT_IDX, ctrl_of(5'h02, RES_16TH));
        wait_for(1'b1, 1'b1, tick_cyc(2) + 100, n);
        chk({7'h00, n >= tick_cyc(1) - 50}, 8'h01);
        chk({7'h00, n < tick_cyc(2) + 100}, 8'h01);
        repeat (100) @(posedge core_clk);
        chk({7'h00, irq_pin_n}, 8'h00);
        rdchk(FLAGS_IDX, 8'h80, 8'h80);
        chk({7'h00, int_oe}, 8'h00);
        chk({7'h00, irq_pin_n}, 8'h01);
        $display("test timeout done");
        // accesses closer than one tick keep the count from expiring
        for (int i = 0; i < 3; i++) begin
            rdchk(WDT_IDX, 8'hFF, 8'h08);
            repeat (6000) @(posedge core_clk);
            chk({7'h00, int_oe}, 8'h00);
        end
        // quarter-second steps: one step spans four base ticks
        u_host.wr(WDT_IDX, ctrl_of(5'h01, RES_QTR));
        wait_for(1'b1, 1'b1, tick_cyc(4) + 100, n);
        chk({7'h00, n >= tick_cyc(3) - 50}, 8'h01);
        chk({7'h00, n < tick_cyc(4) + 100}, 8'h01);
        rdchk(FLAGS_IDX, 8'h80, 8'h80);
        u_host.wr(WDT_IDX, 8'h00);
        repeat (tick_cyc(2) + 100) @(posedge core_clk);
        chk({7'h00, int_oe}, 8'h00);
        rdchk(FLAGS_IDX, 8'h80, 8'h00);
        $display("test restart and disable done");
        u_host.wr(WDT_IDX, 8'h08);
        #1 supply_ok = 1'b0;
        repeat (8) @(posedge core_clk);
        chk({7'h00, rst_oe}, 8'h01);
        chk({7'h00, rst_pin_n}, 8'h00);
        u_host.rd(WDT_IDX, rd_d, ok);
        chk({7'h00, ok}, 8'h00);
        #1 supply_ok = 1'b1;
        repeat (RPU * 2) @(posedge core_clk);
        chk({7'h00, rst_oe}, 8'h01);
        #1 {supply_ok, supply_above_batt} = 2'b00;
        repeat (10) @(posedge core_clk);
        #1 {supply_ok, supply_above_batt} = 2'b11;
        u_host.rd(WDT_IDX, rd_d, ok);
        chk({7'h00, ok}, 8'h00);
        wait_for(1'b0, 1'b0, 200, n);
        chk({7'h00, rst_oe}, 8'h00);
        chk({7'h00, rst_pin_n}, 8'h01);
        rdchk(WDT_IDX, 8'hFF, 8'h00);
        rdchk(INTR_IDX, 8'hA0, 8'h00);
        $display("test supply loss done");
        complete_run();
    end
endmodule : watchdog_and_supply_supervisor_tb_top
`default_nettype wire
